/* File: hw/tcio_top.sv */
// Register block and pin control for timer channels 1 and 2
//
// Summary of operation
// - Each control register holds second-register field high, first low.
// - Code 0000 is compare with pin disabled, and is the reset value.
// - Codes 0001/0101 drive pin low on match, initial 0 or 1.
// - Codes 0010/0110 drive pin high on match, initial 0 or 1.
// - Codes 0011/0111 toggle pin on match, initial 0 or 1.
// - Code 1000 captures the counter on a rising pin edge.
// - Code 1001 captures the counter on a falling pin edge.
// - Codes 1010 and 1011 capture on both pin edges.
// - Channel 1 first register 11xx captures on channel 0 first event.
// - Channel 1 second register 11xx captures on channel 0 third event.
// - Channel 2 codes 1100/1101/1110 capture rising, falling, both edges.
`timescale 1ns/10ps
module tcio_top
    import tcio_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic [CNT_W-1:0]  counter,
    input  wire logic              cnt_tick,
    input  wire logic              chan0_first_event,
    input  wire logic              chan0_third_event,
    input  wire logic              chan1_pin_a_in,
    output logic                   chan1_pin_a_out,
    output logic                   chan1_pin_a_oe,
    input  wire logic              chan1_pin_b_in,
    output logic                   chan1_pin_b_out,
    output logic                   chan1_pin_b_oe,
    input  wire logic              chan2_pin_a_in,
    output logic                   chan2_pin_a_out,
    output logic                   chan2_pin_a_oe,
    input  wire logic              chan2_pin_b_in,
    output logic                   chan2_pin_b_out,
    output logic                   chan2_pin_b_oe,
    output logic [NPIN-1:0]        match_pulse,
    output logic [NPIN-1:0]        capture_pulse
);

    // Unit order: 0 ch1 first, 1 ch1 second, 2 ch2 first, 3 ch2 second
    typedef struct packed {
        logic [NPIN-1:0]             sync1;
        logic [NPIN-1:0]             sync2;
        logic [7:0]                  chan1_io_control;
        logic [7:0]                  chan2_io_control;
        logic [NPIN-1:0][DATA_W-1:0] gr;
        logic [NPIN-1:0]             match_flag;
        logic [NPIN-1:0]             capt_flag;
        logic [DATA_W-1:0]           rdata;
    } tcio_state_t;

    tcio_state_t     state_reg;
    tcio_state_t     state_next;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_out_w;
    logic [NPIN-1:0] pin_oe_w;
    logic [NPIN-1:0] match_w;
    logic [NPIN-1:0] capt_w;
    logic [NPIN-1:0] wr_gr;

    tcio_unit_if ui [NPIN] ();

    assign pin_raw = {chan2_pin_b_in, chan2_pin_a_in,
                      chan1_pin_b_in, chan1_pin_a_in};

    // Field split of each control register
    assign ui[0].field = state_reg.chan1_io_control[FIRST_FLD_LSB +: FLD_W];
    assign ui[1].field = state_reg.chan1_io_control[SECOND_FLD_LSB +: FLD_W];
    assign ui[2].field = state_reg.chan2_io_control[FIRST_FLD_LSB +: FLD_W];
    assign ui[3].field = state_reg.chan2_io_control[SECOND_FLD_LSB +: FLD_W];

    // Only channel 1 has an alternate capture source
    assign ui[0].alt_event = chan0_first_event;
    assign ui[1].alt_event = chan0_third_event;
    assign ui[2].alt_event = 1'b0;
    assign ui[3].alt_event = 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_unit
            assign ui[gi].gr_value = state_reg.gr[gi];
            assign ui[gi].pin_in   = state_reg.sync2[gi];
            assign pin_out_w[gi]   = ui[gi].pin_out;
            assign pin_oe_w[gi]    = ui[gi].pin_oe;
            assign match_w[gi]     = ui[gi].match;
            assign capt_w[gi]      = ui[gi].capture;
            tcio_gr_unit #(
                .CHAN ((gi < 2) ? CHAN_ONE : CHAN_TWO)
            ) u_gr (
                .clk      (clk),
                .rst_n    (rst_n),
                .counter  (counter),
                .cnt_tick (cnt_tick),
                .u        (ui[gi])
            );
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        // Pins are asynchronous; only sync2 feeds the edge logic
        state_next.sync1 = pin_raw;
        state_next.sync2 = state_reg.sync1;

        wr_gr = '0;
        if (wr_stb) begin
            unique case (addr)
                OFS_CHAN1_IO_CONTROL:
                    state_next.chan1_io_control = wdata[7:0];
                OFS_CHAN2_IO_CONTROL:
                    state_next.chan2_io_control = wdata[7:0];
                OFS_CHAN1_FIRST_GR:  wr_gr[0] = 1'b1;
                OFS_CHAN1_SECOND_GR: wr_gr[1] = 1'b1;
                OFS_CHAN2_FIRST_GR:  wr_gr[2] = 1'b1;
                OFS_CHAN2_SECOND_GR: wr_gr[3] = 1'b1;
                OFS_EVENT_FLAGS: begin
                    state_next.match_flag = state_reg.match_flag &
                                            ~wdata[MATCH_LSB +: NPIN];
                    state_next.capt_flag  = state_reg.capt_flag &
                                            ~wdata[CAPT_LSB +: NPIN];
                end
                default: ;
            endcase
        end

        for (int i = 0; i < NPIN; i++) begin
            // A capture in the same cycle as a write wins the register
            if (capt_w[i]) begin
                state_next.gr[i] = counter;
            end else if (wr_gr[i]) begin
                state_next.gr[i] = wdata;
            end
        end
        // Set beats a clear landing in the same cycle
        state_next.match_flag = state_next.match_flag | match_w;
        state_next.capt_flag  = state_next.capt_flag | capt_w;

        state_next.rdata = RD_NONE;
        if (rd_stb) begin
            unique case (addr)
                OFS_CHAN1_IO_CONTROL:
                    state_next.rdata = {8'h00, state_reg.chan1_io_control};
                OFS_CHAN2_IO_CONTROL:
                    state_next.rdata = {8'h00, state_reg.chan2_io_control};
                OFS_CHAN1_FIRST_GR:  state_next.rdata = state_reg.gr[0];
                OFS_CHAN1_SECOND_GR: state_next.rdata = state_reg.gr[1];
                OFS_CHAN2_FIRST_GR:  state_next.rdata = state_reg.gr[2];
                OFS_CHAN2_SECOND_GR: state_next.rdata = state_reg.gr[3];
                OFS_PIN_STATUS: begin
                    state_next.rdata[PIN_OUT_LSB +: NPIN] = pin_out_w;
                    state_next.rdata[PIN_OE_LSB +: NPIN]  = pin_oe_w;
                    state_next.rdata[PIN_IN_LSB +: NPIN]  = state_reg.sync2;
                end
                OFS_EVENT_FLAGS: begin
                    state_next.rdata[MATCH_LSB +: NPIN] = state_reg.match_flag;
                    state_next.rdata[CAPT_LSB +: NPIN]  = state_reg.capt_flag;
                end
                OFS_COUNTER: state_next.rdata = counter;
                default:     state_next.rdata = RD_NONE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg                  <= '0;
            state_reg.chan1_io_control <= CTRL_RST;
            state_reg.chan2_io_control <= CTRL_RST;
            state_reg.gr               <= {NPIN{GR_RST}};
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata           = state_reg.rdata;
    assign chan1_pin_a_out = pin_out_w[0];
    assign chan1_pin_a_oe  = pin_oe_w[0];
    assign chan1_pin_b_out = pin_out_w[1];
    assign chan1_pin_b_oe  = pin_oe_w[1];
    assign chan2_pin_a_out = pin_out_w[2];
    assign chan2_pin_a_oe  = pin_oe_w[2];
    assign chan2_pin_b_out = pin_out_w[3];
    assign chan2_pin_b_oe  = pin_oe_w[3];
    assign match_pulse     = match_w;
    assign capture_pulse   = capt_w;

endmodule // tcio_top

/* File: hw/tcio_pkg.sv */
// Constants and field decoders for the timer channel I/O control
package tcio_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 16;
    localparam int FLD_W  = 4;
    localparam int NPIN   = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CHAN1_IO_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CHAN2_IO_CONTROL = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_CHAN1_FIRST_GR   = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_CHAN1_SECOND_GR  = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CHAN2_FIRST_GR   = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CHAN2_SECOND_GR  = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_PIN_STATUS       = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS      = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_COUNTER          = 4'h8;

    // Field positions inside a control register
    localparam int FIRST_FLD_LSB  = 0;
    localparam int SECOND_FLD_LSB = 4;

    // Field positions inside the pin status and event flag registers
    localparam int PIN_OUT_LSB = 0;
    localparam int PIN_OE_LSB  = 4;
    localparam int PIN_IN_LSB  = 8;
    localparam int MATCH_LSB   = 0;
    localparam int CAPT_LSB    = 4;

    // Reset values
    localparam logic [7:0]        CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] GR_RST   = 16'hffff;
    localparam logic [DATA_W-1:0] RD_NONE  = 16'h0000;

    // Field codes
    localparam logic [FLD_W-1:0] FLD_OFF_INIT0 = 4'h0;
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_LOW    = 2'h1;
    localparam logic [1:0] ACT_HIGH   = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] EDGE_RISE  = 2'h0;
    localparam logic [1:0] EDGE_FALL  = 2'h1;
    localparam logic [1:0] EDGE_BOTH  = 2'h2;
    localparam logic [1:0] EDGE_BOTH2 = 2'h3;

    localparam int CHAN_ONE = 1;
    localparam int CHAN_TWO = 2;

    // Output compare with the pin actually driven
    function automatic logic oc_drive(input logic [FLD_W-1:0] f);
        return (f[3] == 1'b0) && (f[1:0] != ACT_NONE);
    endfunction

    function automatic logic oc_init_level(input logic [FLD_W-1:0] f);
        return f[2];
    endfunction

    function automatic logic is_capture(input logic [FLD_W-1:0] f);
        return f[3];
    endfunction

endpackage

/* File: hw/tcio_unit_if.sv */
// Signals between the register block and one general register unit
`timescale 1ns/10ps
interface tcio_unit_if;
    logic [3:0]  field;
    logic [15:0] gr_value;
    logic        pin_in;
    logic        alt_event;
    logic        match;
    logic        capture;
    logic        pin_out;
    logic        pin_oe;

    modport ctrl (
        output field,
        output gr_value,
        output pin_in,
        output alt_event,
        input  match,
        input  capture,
        input  pin_out,
        input  pin_oe
    );

    modport unit (
        input  field,
        input  gr_value,
        input  pin_in,
        input  alt_event,
        output match,
        output capture,
        output pin_out,
        output pin_oe
    );
endinterface

/* File: hw/tcio_gr_unit.sv */
// Compare and capture logic for one general register and its pin
`timescale 1ns/10ps
module tcio_gr_unit
    import tcio_pkg::*;
#(
    parameter int CHAN = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [CNT_W-1:0] counter,
    input  wire logic             cnt_tick,
    tcio_unit_if.unit             u
);

    typedef struct packed {
        logic             pin_level;
        logic             prev_in;
        logic [FLD_W-1:0] field_prev;
    } tcio_unit_state_t;

    tcio_unit_state_t state_reg;
    tcio_unit_state_t state_next;
    logic             match_c;
    logic             capt_c;
    logic             rise;
    logic             fall;
    logic [1:0]       edge_sel;
    logic             edge_hit;

    always_comb begin
        state_next = state_reg;
        rise       = u.pin_in & ~state_reg.prev_in;
        fall       = ~u.pin_in & state_reg.prev_in;
        state_next.prev_in    = u.pin_in;
        state_next.field_prev = u.field;
        // Match only on a new count, so a stopped counter toggles once
        match_c = oc_drive(u.field) && cnt_tick &&
                  (counter == u.gr_value);
        if ((u.field != state_reg.field_prev) && oc_drive(u.field)) begin
            state_next.pin_level = oc_init_level(u.field);
        end else if (match_c) begin
            unique case (u.field[1:0])
                ACT_LOW:    state_next.pin_level = 1'b0;
                ACT_HIGH:   state_next.pin_level = 1'b1;
                ACT_TOGGLE: state_next.pin_level = ~state_reg.pin_level;
                ACT_NONE:   state_next.pin_level = state_reg.pin_level;
            endcase
        end
        edge_sel = u.field[1:0];
        unique case (edge_sel)
            EDGE_RISE:  edge_hit = rise;
            EDGE_FALL:  edge_hit = fall;
            EDGE_BOTH:  edge_hit = rise | fall;
            EDGE_BOTH2: edge_hit = (u.field[2] == 1'b0) && (rise | fall);
        endcase
        capt_c = 1'b0;
        if (is_capture(u.field)) begin
            if (u.field[2] == 1'b0) begin
                capt_c = edge_hit;
            end else if (CHAN == CHAN_ONE) begin
                capt_c = u.alt_event;
            end else begin
                capt_c = edge_hit;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign u.match   = match_c;
    assign u.capture = capt_c;
    assign u.pin_out = state_reg.pin_level;
    // Codes 0000 and 0100 leave the pin undriven
    assign u.pin_oe  = oc_drive(u.field);

endmodule // tcio_gr_unit

/* File: tb/tcio_asserts.sv */
// Checker for the timer channel pin control block
`timescale 1ns/10ps
module tcio_asserts
    import tcio_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr_stb,
    input wire logic              cnt_tick,
    input wire logic              chan0_first_event,
    input wire logic              chan1_pin_a_out,
    input wire logic              chan1_pin_a_oe,
    input wire logic              chan1_pin_b_oe,
    input wire logic [NPIN-1:0]   match_pulse,
    input wire logic [NPIN-1:0]   capture_pulse
);
    logic [7:0] c1_reg;
    logic       wr1;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    assign wr1 = wr_stb && addr == OFS_CHAN1_IO_CONTROL;
    // Shadow of the control register, so no internal probe is needed
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c1_reg <= CTRL_RST;
        end else if (wr1) begin
            c1_reg <= wdata[7:0];
        end
    end
    a_first_oe_map: assert property (chan1_pin_a_oe ==
        (!c1_reg[3] && c1_reg[1:0] != 2'h0)) else $error("oe a mismatch");
    a_second_oe_map: assert property (chan1_pin_b_oe ==
        (!c1_reg[7] && c1_reg[5:4] != 2'h0)) else $error("oe b mismatch");
    // Level is loaded one edge after the field, so it shows two edges on
    a_init_level: assert property (wr1 && !wdata[3] &&
        wdata[1:0] != 2'h0 && wdata[3:0] != c1_reg[3:0]
        |-> ##2 chan1_pin_a_out == $past(wdata[2], 2))
        else $error("bad init level");
    // A field written one edge earlier loads its initial level instead
    a_match_low: assert property (match_pulse[0] && !$past(wr1) &&
        c1_reg[1:0] == 2'h1 |=> !chan1_pin_a_out) else $error("no low drive");
    a_match_high: assert property (match_pulse[0] && !$past(wr1) &&
        c1_reg[1:0] == 2'h2 |=> chan1_pin_a_out) else $error("no high drive");
    a_match_toggle: assert property (match_pulse[0] && !$past(wr1) &&
        c1_reg[1:0] == 2'h3 |=> chan1_pin_a_out != $past(chan1_pin_a_out))
        else $error("no toggle");
    a_match_gated: assert property (match_pulse[0] |-> cnt_tick &&
        !c1_reg[3] && c1_reg[1:0] != 2'h0) else $error("stray match");
    a_alt_capture: assert property (chan0_first_event &&
        c1_reg[3:2] == 2'h3 |-> capture_pulse[0]) else $error("no capture");
endmodule // tcio_asserts

bind tcio_top tcio_asserts u_tcio_asserts (.*);

/* File: tb/tcio_pin_model.sv */
// Far side of the timer pins: external drivers and wire resolution
`timescale 1ns/10ps
module tcio_pin_model (
    input  wire logic [3:0] ext_level,
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    output logic      [3:0] pin_in
);
    // A driven pin reads back its own level, else the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // tcio_pin_model

/* File: tb/testbench.sv */
// Self-checking bench for the timer channel pin control block
`timescale 1ns/10ps
module testbench;
    import tcio_pkg::*;
    localparam logic [15:0] RISE_M = 16'h5d00;
    localparam logic [15:0] FALL_M = 16'h6e00;
    logic              clk, rst_n, wr_stb, rd_stb, cnt_tick;
    logic              chan0_first_event, chan0_third_event;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [CNT_W-1:0]  counter;
    logic [NPIN-1:0]   match_pulse, capture_pulse, ext_level, oe_v, out_v;
    logic chan1_pin_a_in, chan1_pin_b_in, chan2_pin_a_in, chan2_pin_b_in;
    logic chan1_pin_a_out, chan1_pin_b_out, chan2_pin_a_out;
    logic chan2_pin_b_out, chan1_pin_a_oe, chan1_pin_b_oe;
    logic chan2_pin_a_oe, chan2_pin_b_oe;
    int   n_fail = 0;
    int   tests_run = 0;
    assign oe_v = {chan2_pin_b_oe, chan2_pin_a_oe, chan1_pin_b_oe,
                   chan1_pin_a_oe};
    assign out_v = {chan2_pin_b_out, chan2_pin_a_out, chan1_pin_b_out,
                    chan1_pin_a_out};
    tcio_top u_tcio_top (.*);
    tcio_pin_model u_tcio_pin_model (.ext_level(ext_level),
        .pin_out(out_v), .pin_oe(oe_v), .pin_in({chan2_pin_b_in,
        chan2_pin_a_in, chan1_pin_b_in, chan1_pin_a_in}));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic t_reset;
        rd_chk(OFS_CHAN1_IO_CONTROL, 16'h0000);
        rd_chk(OFS_CHAN2_IO_CONTROL, 16'h0000);
        rd_chk(4'hf, RD_NONE);
        check({12'h000, oe_v}, 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_oc_codes;
        logic [3:0] c;
        logic [3:0] e;
        for (int i = 0; i < 8; i++) begin
            c = i[3:0];
            e = {4{c[1:0] != 2'h0}};
            wr(OFS_CHAN1_IO_CONTROL, {8'h00, c, c});
            wr(OFS_CHAN2_IO_CONTROL, {8'h00, c, c});
            check({12'h000, oe_v}, {12'h000, e});
            // Initial level lands one edge after the field changes
            @(posedge clk);
            #1;
            check({12'h000, out_v & e}, {12'h000, e & {4{c[2]}}});
            rd_chk(OFS_CHAN2_IO_CONTROL, {8'h00, c, c});
        end
        wr(OFS_CHAN1_IO_CONTROL, 16'h0020);
        check({14'h0, oe_v[1:0]}, 16'h0002);
        $display("compare code test done");
    endtask
    task automatic t_compare;
        logic [3:0] c;
        logic       exp;
        for (int i = 0; i < 8; i++) begin
            c = i[3:0];
            exp = (c[1:0] == 2'h3) ? !c[2] : c[1];
            wr(OFS_CHAN1_FIRST_GR, 16'h1230 + 16'(i));
            wr(OFS_CHAN1_IO_CONTROL, {12'h000, c});
            @(posedge clk);
            counter <= 16'h1230 + 16'(i);
            cnt_tick <= 1'b1;
            #1;
            check({15'h0, match_pulse[0]}, {15'h0, c[1:0] != 2'h0});
            @(posedge clk);
            cnt_tick <= 1'b0;
            #1;
            check({15'h0, chan1_pin_a_out & e_of(c)}, {15'h0, exp});
        end
        rd_chk(OFS_EVENT_FLAGS, 16'h0001);
        wr(OFS_EVENT_FLAGS, 16'h00ff);
        rd_chk(OFS_EVENT_FLAGS, 16'h0000);
        rd_chk(OFS_PIN_STATUS, 16'h0cdc);
        $display("compare match test done");
    endtask
    function automatic logic e_of(input logic [3:0] c);
        return c[1:0] != 2'h0;
    endfunction
    task automatic t_capture;
        logic [15:0] g;
        int          n;
        wr(OFS_CHAN2_IO_CONTROL, 16'h0000);
        repeat (4) @(posedge clk);
        for (int i = 8; i < 16; i++) begin
            wr(OFS_CHAN2_IO_CONTROL, 16'(i));
            wr(OFS_CHAN2_FIRST_GR, 16'h0000);
            g = 16'h0000;
            for (int k = 0; k < 2; k++) begin
                @(posedge clk);
                counter <= 16'h4400 + 16'(i * 2 + k);
                ext_level[2] <= (k == 0);
                n = 0;
                repeat (6) begin
                    @(posedge clk);
                    #1;
                    n += int'(capture_pulse[2]);
                end
                check(16'(n), {15'h0, k ? FALL_M[i] : RISE_M[i]});
                g = (k ? FALL_M[i] : RISE_M[i]) ? counter : g;
                rd_chk(OFS_CHAN2_FIRST_GR, g);
            end
        end
        $display("capture test done");
    endtask
    task automatic t_alt;
        wr(OFS_CHAN1_IO_CONTROL, 16'h00cc);
        wr(OFS_CHAN1_FIRST_GR, 16'h0000);
        wr(OFS_CHAN1_SECOND_GR, 16'h0000);
        @(posedge clk);
        counter <= 16'h5a5a;
        chan0_first_event <= 1'b1;
        #1;
        check({12'h000, capture_pulse}, 16'h0001);
        @(posedge clk);
        chan0_first_event <= 1'b0;
        chan0_third_event <= 1'b1;
        counter <= 16'ha5a5;
        #1;
        check({12'h000, capture_pulse}, 16'h0002);
        @(posedge clk);
        chan0_third_event <= 1'b0;
        rd_chk(OFS_CHAN1_FIRST_GR, 16'h5a5a);
        rd_chk(OFS_CHAN1_SECOND_GR, 16'ha5a5);
        $display("channel 0 event test done");
    endtask
    initial begin
        rst_n = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        cnt_tick = 1'b0;
        chan0_first_event = 1'b0;
        chan0_third_event = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        counter = 16'h0000;
        ext_level = 4'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_oc_codes();
        t_compare();
        t_capture();
        t_alt();
        print_verdict();
    end
    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule // testbench
